/* File: bench/ftbs_host_model.sv */
`timescale 1ns/10ps
module ftbs_host_model (
  // Clock
  input  wire logic                             clk,
  // Master side controls
  output ftbs_pkg::ftbs_in_t                    bus,
  // Data wire
  input  wire logic [ftbs_pkg::WORD_W-1:0]      dev_q,
  input  wire logic                             dev_oe_n,
  output logic      [ftbs_pkg::WORD_W-1:0]      wire_q
);
  logic desel;

  initial begin
    bus   = ftbs_pkg::IN_RESET;
    desel = 1'b0;
  end

  // Master owns the wire on its write cycles, else the device while it drives
  assign wire_q = (dev_oe_n || !bus.global_write_n ||
                   !bus.byte_write_enable_n) ?
                  {bus.parity, bus.data} : dev_q;

  // Lines change just after an edge and hold one cycle
  task drive(input logic ps_n, cs_n, adv_n, gw_n, bwe_n,
             input logic [3:0] sel_n,
             input logic [ftbs_pkg::ADDR_W-1:0] a,
             input logic [ftbs_pkg::WORD_W-1:0] d);
    logic wr;
    wr = !(gw_n && bwe_n);
    @(posedge clk);
    // Released data shows the inverse so stale values never match
    bus <= '{a, wr ? d[31:0] : ~bus.data, wr ? d[35:32] : ~bus.parity,
             ps_n, cs_n, adv_n, 1'b0, !desel, 1'b0, sel_n, bwe_n, gw_n};
  endtask : drive
endmodule : ftbs_host_model

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ord = 1'b0;
  logic        oe_in = 1'b0;
  logic        sleep = 1'b0;
  int          error_cnt = 0;
  int          n_checks = 0;
  ftbs_pkg::ftbs_in_t hb;
  wire  [35:0] q_w;
  wire  [35:0] q_o;
  wire         oe_o;
  logic [35:0] mem [4];
  localparam logic [18:0] BASE = 19'h2A5C4;
  // Order, advance in cycles 1..3, beat offsets with beat 0 lowest
  logic [11:0] rows [10] = '{12'h0E4, 12'h039, 12'h04E, 12'h093,
    12'h8E4, 12'h8B1, 12'h84E, 12'h81B, 12'h7AA, 12'h294};

  always #20 clk = ~clk;

  ftbs_host_model host (.clk(clk), .bus(hb), .dev_q(q_o),
    .dev_oe_n(oe_o), .wire_q(q_w));

  ftbs_top DUT (.clk(clk), .rst_b(rst_b), .addr(hb.addr),
    .proc_addr_strobe_n(hb.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(hb.ctrl_addr_strobe_n),
    .burst_advance_n(hb.burst_advance_n), .burst_order(ord),
    .chip_sel_pipelined_n(hb.chip_sel_pipelined_n),
    .chip_sel_depth_hi(hb.chip_sel_depth_hi),
    .chip_sel_depth_lo_n(hb.chip_sel_depth_lo_n),
    .byte_write_sel_n(hb.byte_write_sel_n),
    .byte_write_enable_n(hb.byte_write_enable_n),
    .global_write_n(hb.global_write_n), .out_enable_n(oe_in),
    .sleep_request(sleep), .data_io_in(q_w[31:0]),
    .data_io_out(q_o[31:0]), .parity_io_in(q_w[35:32]),
    .parity_io_out(q_o[35:32]), .data_io_oe_n(oe_o));

  task summarize;
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // Address lines carry junk after the start to prove the latch
  task burst(input logic [11:0] r, input logic ps_n);
    logic [18:0] a;
    a = BASE | 19'(r[1:0]);
    ord <= r[11];
    host.drive(ps_n, !ps_n, 1'b1, 1'b1, 1'b1, 4'hF, a, '0);
    for (int k = 0; k < 5; k++) begin
      host.drive(1'b1, 1'b1, k < 3 ? r[8+k] : 1'b1, 1'b1, 1'b1, 4'hF,
                 ~a, '0);
      if (k > 0) begin
        @(negedge clk);
        `CHK(q_o, mem[r[2*k-1 -: 2]])
        `CHK(oe_o, 1'b0)
      end
    end
  endtask : burst

  initial begin
    #80000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK(oe_o, 1'b1)
    `CHK(q_o, 36'h000000000)
    @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      mem[i] = 36'h310203040 + 36'h404050607 * i;
      host.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, BASE + 19'(i),
                 mem[i]);
    end
    for (int r = 0; r < 10; r++)
      burst(rows[r], r % 2 == 0);
    // Writes that must leave the array alone, around a lane merge
    host.drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, BASE, '0);
    host.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0, BASE + 19'h1, '0);
    host.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hA, BASE + 19'h2,
               36'hFFFFFFFFF);
    mem[2] = mem[2] | 36'h500FF00FF;
    host.desel = 1'b1;
    host.drive(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, BASE + 19'h3, '0);
    host.desel = 1'b0;
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, BASE, '0);
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, BASE, '0);
    @(negedge clk);
    `CHK(oe_o, 1'b1)
    burst(12'h0E4, 1'b1);
    // Four advances wrap back to the start word
    host.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, BASE + 19'h2, '0);
    repeat (4) host.drive(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, ~BASE, '0);
    host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, ~BASE, '0);
    @(posedge clk);
    @(negedge clk);
    `CHK(q_o, mem[2])
    // Output enable and sleep act between edges
    host.drive(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, BASE + 19'h1, '0);
    repeat (2) @(posedge clk);
    oe_in <= 1'b1;
    #5;
    `CHK(oe_o, 1'b1)
    @(posedge clk);
    oe_in <= 1'b0;
    sleep <= 1'b1;
    #5;
    `CHK(oe_o, 1'b1)
    @(posedge clk);
    sleep <= 1'b0;
    #5;
    `CHK(oe_o, 1'b1)
    @(posedge clk);
    #5;
    `CHK(oe_o, 1'b0)
    `CHK(q_o, mem[1])
    summarize();
  end
endmodule : testbench

/* File: design/ftbs_mem.sv */
`timescale 1ns/10ps
module ftbs_mem (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Access
  input  wire logic [ftbs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ftbs_pkg::LANES-1:0]   lane_we,
  input  wire logic [ftbs_pkg::WORD_W-1:0]  wdata,
  output logic      [ftbs_pkg::WORD_W-1:0]  rdata
);

  // No reset on the array: contents are undefined after power-up
  logic [ftbs_pkg::WORD_W-1:0] array_mem [ftbs_pkg::DEPTH];

  always_ff @(posedge clk) begin
    for (int i = 0; i < ftbs_pkg::LANES; i++) begin
      if (lane_we[i]) begin
        array_mem[addr][i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] <=
          wdata[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W];
      end
    end
  end

  // Read returns the old word on a same-address write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= ftbs_pkg::WORD_RESET;
    end else begin
      rdata <= array_mem[addr];
    end
  end

endmodule : ftbs_mem

/* File: design/ftbs_top.sv */
`timescale 1ns/10ps
module ftbs_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Address and burst control
  input  wire logic [ftbs_pkg::ADDR_W-1:0]  addr,
  input  wire logic                         proc_addr_strobe_n,
  input  wire logic                         ctrl_addr_strobe_n,
  input  wire logic                         burst_advance_n,
  input  wire logic                         burst_order,
  // Chip selects
  input  wire logic                         chip_sel_pipelined_n,
  input  wire logic                         chip_sel_depth_hi,
  input  wire logic                         chip_sel_depth_lo_n,
  // Write enables
  input  wire logic [ftbs_pkg::LANES-1:0]   byte_write_sel_n,
  input  wire logic                         byte_write_enable_n,
  input  wire logic                         global_write_n,
  // Asynchronous controls
  input  wire logic                         out_enable_n,
  input  wire logic                         sleep_request,
  // Data bus, split into in, out and enable
  input  wire logic [ftbs_pkg::DATA_W-1:0]  data_io_in,
  output logic      [ftbs_pkg::DATA_W-1:0]  data_io_out,
  input  wire logic [ftbs_pkg::LANES-1:0]   parity_io_in,
  output logic      [ftbs_pkg::LANES-1:0]   parity_io_out,
  output logic                              data_io_oe_n
);

  function automatic logic [ftbs_pkg::CNT_W-1:0] burst_low(
    input logic                       order,
    input logic [ftbs_pkg::CNT_W-1:0] first,
    input logic [ftbs_pkg::CNT_W-1:0] cnt
  );
    burst_low = order ? (first ^ cnt) : (first + cnt);
  endfunction : burst_low

  ftbs_pkg::ftbs_in_t in_reg, in_next;
  logic [ftbs_pkg::ADDR_W-1:0] base_reg, base_next;
  logic [ftbs_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic                        sel_reg, sel_next;
  logic                        rd_valid_reg, rd_valid_next;
  logic                        start;
  logic                        wr_ok;
  logic [ftbs_pkg::ADDR_W-1:0] mem_addr;
  logic [ftbs_pkg::LANES-1:0]  lane_we;
  logic [ftbs_pkg::WORD_W-1:0] wdata;
  logic [ftbs_pkg::WORD_W-1:0] rdata;

  // Input capture: every pin but burst_order, out_enable_n and sleep_request goes through this register before it acts
  always_comb begin
    in_next = '{addr: addr, data: data_io_in, parity: parity_io_in,
      proc_addr_strobe_n: proc_addr_strobe_n,
      ctrl_addr_strobe_n: ctrl_addr_strobe_n,
      burst_advance_n: burst_advance_n,
      chip_sel_pipelined_n: chip_sel_pipelined_n,
      chip_sel_depth_hi: chip_sel_depth_hi,
      chip_sel_depth_lo_n: chip_sel_depth_lo_n,
      byte_write_sel_n: byte_write_sel_n,
      byte_write_enable_n: byte_write_enable_n,
      global_write_n: global_write_n};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_reg <= ftbs_pkg::IN_RESET;
    end else begin
      in_reg <= in_next;
    end
  end

  // Burst address and access control
  always_comb begin
    start     = !in_reg.proc_addr_strobe_n ||
                !in_reg.ctrl_addr_strobe_n;
    base_next = base_reg;
    cnt_next  = cnt_reg;
    sel_next  = sel_reg;
    if (start) begin
      base_next = in_reg.addr;
      cnt_next  = ftbs_pkg::CNT_RESET;
      sel_next  = !in_reg.chip_sel_pipelined_n &&
                  in_reg.chip_sel_depth_hi &&
                  !in_reg.chip_sel_depth_lo_n;
    end else if (!in_reg.burst_advance_n) begin
      cnt_next  = cnt_reg + 2'h1;
    end
    mem_addr = {base_next[ftbs_pkg::ADDR_W-1:ftbs_pkg::CNT_W],
                burst_low(burst_order,
                          base_next[ftbs_pkg::CNT_W-1:0],
                          cnt_next)};
    // A processor strobe never opens with a write
    wr_ok = sel_next && !sleep_request &&
            in_reg.proc_addr_strobe_n;
    if (!wr_ok) begin
      lane_we = ftbs_pkg::LANES_NONE;
    end else if (!in_reg.global_write_n) begin
      lane_we = ftbs_pkg::LANES_ALL;
    end else if (!in_reg.byte_write_enable_n) begin
      lane_we = ~in_reg.byte_write_sel_n;
    end else begin
      lane_we = ftbs_pkg::LANES_NONE;
    end
    for (int i = 0; i < ftbs_pkg::LANES; i++) begin
      wdata[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] =
        {in_reg.parity[i], in_reg.data[i*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W]};
    end
    // A processor strobe start reads even with write enables low
    rd_valid_next = sel_next && !sleep_request &&
                    (!in_reg.proc_addr_strobe_n ||
                     (in_reg.global_write_n &&
                      in_reg.byte_write_enable_n));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_reg     <= ftbs_pkg::ADDR_RESET;
      cnt_reg      <= ftbs_pkg::CNT_RESET;
      sel_reg      <= 1'b0;
      rd_valid_reg <= 1'b0;
    end else begin
      base_reg     <= base_next;
      cnt_reg      <= cnt_next;
      sel_reg      <= sel_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Read word leaves the array register one edge after the address
  ftbs_mem u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .addr    (mem_addr),
    .lane_we (lane_we),
    .wdata   (wdata),
    .rdata   (rdata)
  );

  always_comb begin
    for (int i = 0; i < ftbs_pkg::LANES; i++) begin
      data_io_out[i*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W] =
        rdata[i*ftbs_pkg::LANE_W +: ftbs_pkg::BYTE_W];
      parity_io_out[i] = rdata[i*ftbs_pkg::LANE_W + ftbs_pkg::BYTE_W];
    end
  end

  // Enable is gated after the flop so the bus releases without a clock
  assign data_io_oe_n = !rd_valid_reg || out_enable_n ||
                        sleep_request;

  property p_first_beat;
    @(posedge clk) disable iff (!rst_b)
      (!proc_addr_strobe_n && !chip_sel_pipelined_n &&
       chip_sel_depth_hi && !chip_sel_depth_lo_n)
      ##1 !sleep_request |=> rd_valid_reg;
  endproperty
  a_first_beat: assert property (p_first_beat)
    else $error("first read beat not valid two clocks after strobe");

  property p_next_beat;
    @(posedge clk) disable iff (!rst_b)
      (rd_valid_next && proc_addr_strobe_n && ctrl_addr_strobe_n &&
       !burst_advance_n && global_write_n && byte_write_enable_n)
      ##1 !sleep_request |=>
        rd_valid_reg && cnt_reg == $past(cnt_reg) + 2'h1;
  endproperty
  a_next_beat: assert property (p_next_beat)
    else $error("following beat not delivered one clock later");

  property p_capture;
    @(posedge clk) disable iff (!rst_b)
      !proc_addr_strobe_n ##1 1'b1 |=> base_reg == $past(addr, 2);
  endproperty
  a_capture: assert property (p_capture)
    else $error("strobed address not captured");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n)
      ##1 1'b1 |=> $stable(base_reg) && $stable(cnt_reg) && $stable(sel_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("burst state moved without strobe or advance");

  property p_wrap;
    @(posedge clk) disable iff (!rst_b)
      (cnt_reg == 2'h3 && !in_reg.burst_advance_n &&
       in_reg.proc_addr_strobe_n && in_reg.ctrl_addr_strobe_n)
      |=> cnt_reg == 2'h0 && $stable(base_reg);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst counter did not wrap within four words");

  property p_linear;
    @(posedge clk) disable iff (!rst_b)
      !burst_order && !start |->
        mem_addr[1:0] == base_reg[1:0] + cnt_next &&
        mem_addr[ftbs_pkg::ADDR_W-1:2] == base_reg[ftbs_pkg::ADDR_W-1:2];
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst address wrong");

  property p_interleave;
    @(posedge clk) disable iff (!rst_b)
      burst_order && !start |-> mem_addr[1:0] == (base_reg[1:0] ^ cnt_next);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved burst address wrong");

  property p_async_off;
    @(posedge clk) disable iff (!rst_b)
      (out_enable_n || sleep_request) |-> data_io_oe_n;
  endproperty
  a_async_off: assert property (p_async_off)
    else $error("bus driven while output disabled or asleep");

  property p_global_write;
    @(posedge clk) disable iff (!rst_b)
      (!global_write_n && proc_addr_strobe_n)
      ##1 (sel_next && !sleep_request) |-> lane_we == 4'hF;
  endproperty
  a_global_write: assert property (p_global_write)
    else $error("global write missed a lane");

  property p_byte_write;
    @(posedge clk) disable iff (!rst_b)
      (global_write_n && !byte_write_enable_n && proc_addr_strobe_n)
      ##1 (sel_next && !sleep_request) |->
        lane_we == ~$past(byte_write_sel_n);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write lanes do not follow selects");

endmodule : ftbs_top

/* File: shared/ftbs_pkg.sv */
package ftbs_pkg;

  localparam int ADDR_W  = 19;
  localparam int LANES   = 4;
  localparam int BYTE_W  = 8;
  localparam int LANE_W  = BYTE_W + 1;
  localparam int WORD_W  = LANES * LANE_W;
  localparam int DATA_W  = LANES * BYTE_W;
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int CNT_W   = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0]  parity;
    logic              proc_addr_strobe_n;
    logic              ctrl_addr_strobe_n;
    logic              burst_advance_n;
    logic              chip_sel_pipelined_n;
    logic              chip_sel_depth_hi;
    logic              chip_sel_depth_lo_n;
    logic [LANES-1:0]  byte_write_sel_n;
    logic              byte_write_enable_n;
    logic              global_write_n;
  } ftbs_in_t;

  localparam ftbs_in_t IN_RESET = '{
    addr: '0, data: '0, parity: '0,
    proc_addr_strobe_n: 1'b1, ctrl_addr_strobe_n: 1'b1,
    burst_advance_n: 1'b1, chip_sel_pipelined_n: 1'b1,
    chip_sel_depth_hi: 1'b0, chip_sel_depth_lo_n: 1'b1,
    byte_write_sel_n: 4'hF, byte_write_enable_n: 1'b1,
    global_write_n: 1'b1};

  localparam logic [CNT_W-1:0]  CNT_RESET   = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 19'h00000;
  localparam logic [LANES-1:0]  LANES_ALL   = 4'hF;
  localparam logic [LANES-1:0]  LANES_NONE  = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RESET  = 36'h000000000;

endpackage : ftbs_pkg
